// ==== hw/seebc_top.sv ====
// Serial EEPROM bus control: memory array, test byte, busy timer and bus slave
`timescale 1ns/1ps
module seebc_top #(
  parameter int PROG_CYCLES = seebc_pkg::PROG_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic frame_select_line_i,
  input wire logic bus_clock_line_i,
  input wire logic bus_data_i,
  output logic bus_data_o,
  output logic bus_data_oe_o,
  input wire logic unlock_i,
  input wire logic addr_option_i,
  output logic pump_enable_o,
  output logic [2:0] ref_shift_up_o,
  output logic [2:0] ref_shift_down_o
);
  typedef enum logic [1:0] {
    SEEBC_IDLE = 2'b01,
    SEEBC_BUSY = 2'b10
  } seebc_state_e;

  seebc_ctl_if ctl ();
  logic [7:0] mem [0:511];
  logic [9:0] mem_addr;
  logic [7:0] test_mode_byte;
  seebc_state_e state;
  logic [31:0] timer;
  logic [9:0] prog_addr;
  logic [7:0] prog_data;
  logic prog_block;
  logic [1:0] prog_set;
  logic [1:0] sel_s;
  logic [1:0] clk_s;
  logic [1:0] dat_s;
  logic [1:0] unl_s;
  logic [1:0] opt_s;
  logic shift_oe;
  logic busy;

  assign busy = (state == SEEBC_BUSY);
  assign ctl.busy = busy;

  // Pins cross from the bus domain; the first stage feeds only the second
  always_ff @(posedge clock_i) begin
    sel_s <= {sel_s[0], frame_select_line_i};
    clk_s <= {clk_s[0], bus_clock_line_i};
    dat_s <= {dat_s[0], bus_data_i};
    unl_s <= {unl_s[0], unlock_i};
    opt_s <= {opt_s[0], addr_option_i};
  end

  seebc_shifter u_shift (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .sel_i(sel_s[1]),
    .clk_i(clk_s[1]),
    .dat_i(dat_s[1]),
    .alt_i(opt_s[1]),
    .dat_oe_o(shift_oe),
    .ctl(ctl.shifter)
  );

  function automatic logic protected_addr(input logic [9:0] a);
    protected_addr = (a <= seebc_pkg::USER_TOP) && (a[5:4] == 2'b00);
  endfunction

  function automatic logic block_hit(input logic [8:0] a, input logic [1:0] set);
    block_hit = !set[1] || (a[0] == set[0]);
  endfunction

  // Read word source, low byte only; status reads the busy flag
  always_comb begin
    ctl.rdata = 8'hff;
    if (mem_addr == seebc_pkg::PROGRAM_STATUS_ADDR) begin
      ctl.rdata = 8'h00;
      ctl.rdata[seebc_pkg::BUSY_BIT] = busy;
    end else if (mem_addr == seebc_pkg::TEST_MODE_BYTE_ADDR) begin
      ctl.rdata = test_mode_byte;
    end else if (mem_addr <= seebc_pkg::USER_TOP) begin
      ctl.rdata = mem[mem_addr[8:0]];
    end
  end

  // Address register has no reset, so a reset leaves it intact
  always_ff @(posedge clock_i) begin
    if (resetn_i && ctl.frame_done && ctl.op == 2'd1 && !busy) begin
      mem_addr <= ctl.wdata[9:0];
    end
  end

  // Busy sequencer; a start request during busy is dropped
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= SEEBC_IDLE;
      timer <= 32'd0;
      prog_addr <= 10'h000;
      prog_data <= 8'h00;
      prog_block <= 1'b0;
      prog_set <= 2'b00;
    end else begin
      unique case (state)
        SEEBC_IDLE: begin
          if (ctl.frame_done && ctl.op == 2'd3) begin
            state <= SEEBC_BUSY;
            timer <= 32'(PROG_CYCLES);
            prog_addr <= mem_addr;
            prog_data <= ctl.wdata[7:0];
            prog_block <= test_mode_byte[seebc_pkg::TB_ENABLE] && test_mode_byte[seebc_pkg::TB_BLOCK]
              && !mem_addr[9];
            prog_set <= mem_addr[1:0];
          end
        end
        SEEBC_BUSY: begin
          if (timer == 32'd1) state <= SEEBC_IDLE;
          timer <= timer - 32'd1;
        end
        default: state <= SEEBC_IDLE;
      endcase
    end
  end

  logic pump_ok;
  assign pump_ok = !(test_mode_byte[seebc_pkg::TB_ENABLE] && test_mode_byte[seebc_pkg::TB_PUMP_OFF]);

  // Cells are written at the end of the busy time; abort by reset writes nothing
  generate
    for (genvar g = 0; g < 512; g++) begin : g_cell
      always_ff @(posedge clock_i) begin
        if (resetn_i && busy && timer == 32'd1 && pump_ok
            && (!protected_addr(10'(g)) || unl_s[1])) begin
          if (prog_block ? block_hit(9'(g), prog_set) : (prog_addr == 10'(g))) begin
            mem[g] <= prog_data;
          end
        end
      end
    end
  endgenerate

  // Test byte takes effect when its busy time ends and holds until reset or the next write to its address
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      test_mode_byte <= seebc_pkg::TEST_MODE_BYTE_RST;
    end else if (busy && timer == 32'd1 && prog_addr == seebc_pkg::TEST_MODE_BYTE_ADDR) begin
      test_mode_byte <= prog_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      bus_data_o <= 1'b0;
      bus_data_oe_o <= 1'b0;
      pump_enable_o <= 1'b0;
      ref_shift_up_o <= 3'b000;
      ref_shift_down_o <= 3'b000;
    end else begin
      bus_data_o <= 1'b0;
      bus_data_oe_o <= shift_oe;
      pump_enable_o <= busy && pump_ok;
      if (test_mode_byte[seebc_pkg::TB_ENABLE]) begin
        ref_shift_up_o <= {1'b0, test_mode_byte[seebc_pkg::TB_SHIFT_P06], test_mode_byte[seebc_pkg::TB_SHIFT_P03]}
          + {2'b00, 1'b0};
        ref_shift_down_o <= {1'b0, test_mode_byte[seebc_pkg::TB_SHIFT_M06], test_mode_byte[seebc_pkg::TB_SHIFT_M03]};
      end else begin
        ref_shift_up_o <= 3'b000;
        ref_shift_down_o <= 3'b000;
      end
    end
  end

  AST_BUSY_HOLDS: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ($rose(busy)) |-> busy [*8])
    else $error("busy cycle ended early");
  AST_ADDR_FROZEN: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (busy && $past(busy)) |-> $stable(mem_addr))
    else $error("address changed while busy");
  AST_NO_RESTART: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (busy && timer != 32'd1) |=> $stable(prog_data))
    else $error("program restarted while busy");
  AST_STATUS_BIT: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (mem_addr == seebc_pkg::PROGRAM_STATUS_ADDR) |-> ctl.rdata[1] == busy)
    else $error("status bit wrong");
  AST_RESET_ABORT: assert property (@(posedge clock_i)
    (!resetn_i) |=> !busy && test_mode_byte == 8'h00)
    else $error("reset did not abort");
  AST_PUMP_OFF: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (test_mode_byte[seebc_pkg::TB_ENABLE] && test_mode_byte[seebc_pkg::TB_PUMP_OFF]) |=> !pump_enable_o)
    else $error("pump on while disabled");
  AST_PROTECT: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (busy && timer == 32'd1 && !prog_block && protected_addr(prog_addr) && !unl_s[1])
      |=> $stable(mem[prog_addr[8:0]]))
    else $error("protected cell written");
  AST_REF_SHIFT: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (!test_mode_byte[seebc_pkg::TB_ENABLE]) |=> ref_shift_up_o == 3'b000 && ref_shift_down_o == 3'b000)
    else $error("reference shifted without test enable");
endmodule // seebc_top

// ==== hw/seebc_pkg.sv ====
// Shared constants for the serial EEPROM bus control block
package seebc_pkg;
  localparam int ADDR_W = 10;
  localparam logic [9:0] USER_TOP = 10'h1ff;
  localparam logic [9:0] TEST_MODE_BYTE_ADDR = 10'h204;
  localparam logic [9:0] PROGRAM_STATUS_ADDR = 10'h20e;
  localparam logic [7:0] TEST_MODE_BYTE_RST = 8'h00;
  localparam int BUSY_BIT = 1;
  localparam logic [7:0] BA_ENTER = 8'h80;
  localparam logic [7:0] BA_READ = 8'h81;
  localparam logic [7:0] BA_PROG = 8'h83;
  localparam logic [7:0] BA_ALT_OFS = 8'h04;
  localparam int TB_SHIFT_P06 = 0;
  localparam int TB_SHIFT_P03 = 2;
  localparam int TB_PUMP_OFF = 3;
  localparam int TB_SHIFT_M06 = 4;
  localparam int TB_ENABLE = 5;
  localparam int TB_SHIFT_M03 = 6;
  localparam int TB_BLOCK = 7;
  localparam int CLK_HZ = 40000000;
  localparam int PROG_TIME_US = 8000;
  localparam int PROG_CYCLES = (PROG_TIME_US * (CLK_HZ / 1000000));
endpackage

// ==== hw/seebc_ctl_if.sv ====
// Interface carrying decoded frames from the bus shifter to the memory core
`timescale 1ns/1ps
interface seebc_ctl_if;
  logic frame_done;
  logic [1:0] op;
  logic [15:0] wdata;
  logic [7:0] rdata;
  logic busy;
  modport shifter (output frame_done, output op, output wdata, input rdata, input busy);
  modport core (input frame_done, input op, input wdata, output rdata, output busy);
endinterface

// ==== hw/seebc_shifter.sv ====
// Serial bus framing: address byte, data bits LSB first, end pulse
`timescale 1ns/1ps
module seebc_shifter (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic sel_i,
  input wire logic clk_i,
  input wire logic dat_i,
  input wire logic alt_i,
  output logic dat_oe_o,
  seebc_ctl_if.shifter ctl
);
  logic sel_q;
  logic clk_q;
  logic [7:0] addr_sh;
  logic [15:0] data_sh;
  logic [4:0] cnt;
  logic in_addr;
  logic in_data;
  logic [7:0] base;
  logic clk_rise;
  logic sel_rise;
  logic sel_fall;
  assign clk_rise = clk_i & ~clk_q;
  assign sel_rise = sel_i & ~sel_q;
  assign sel_fall = ~sel_i & sel_q;
  assign base = alt_i ? seebc_pkg::BA_ALT_OFS : 8'h00;

  function automatic logic [1:0] match(input logic [7:0] a, input logic [7:0] b);
    if (a == seebc_pkg::BA_ENTER + b) match = 2'd1;
    else if (a == seebc_pkg::BA_READ + b) match = 2'd2;
    else if (a == seebc_pkg::BA_PROG + b) match = 2'd3;
    else match = 2'd0;
  endfunction

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sel_q <= 1'b1; // Idle level, so no false edge follows reset
      clk_q <= 1'b1;
    end else begin
      sel_q <= sel_i;
      clk_q <= clk_i;
    end
  end

  // Edge tracking has no timer, so any pause on the bus keeps the bit position
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cnt <= 5'd0;
      in_addr <= 1'b0;
      in_data <= 1'b0;
      addr_sh <= 8'h00;
      data_sh <= 16'h0000;
      ctl.op <= 2'd0;
    end else if (sel_fall) begin
      // A fall outside the data phase opens a frame; inside it, it is the end pulse
      in_addr <= !in_data;
      in_data <= 1'b0;
    end else if (sel_rise && in_addr) begin
      in_addr <= 1'b0;
      in_data <= 1'b1;
      cnt <= 5'd0;
      ctl.op <= match(addr_sh, base);
    end else if (clk_rise) begin
      if (in_addr) begin
        addr_sh <= {dat_i, addr_sh[7:1]};
      end else if (in_data && cnt != 5'd16) begin
        data_sh <= {dat_i, data_sh[15:1]};
        cnt <= cnt + 5'd1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ctl.frame_done <= 1'b0;
      ctl.wdata <= 16'h0000;
    end else begin
      ctl.frame_done <= sel_fall && in_data && ctl.op != 2'd0 && cnt != 5'd0;
      if (sel_fall && in_data) begin
        ctl.wdata <= (ctl.op == 2'd1) ? data_sh >> (5'd16 - cnt) : data_sh;
      end
    end
  end

  // Open drain: pull low for zero bits of the read word, LSB first
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      dat_oe_o <= 1'b0;
    end else if (sel_rise && in_addr && match(addr_sh, base) == 2'd2) begin
      dat_oe_o <= ~ctl.rdata[0]; // Bit 0 must stand before the first data clock
    end else if (in_data && ctl.op == 2'd2 && clk_rise && cnt < 5'd7) begin
      dat_oe_o <= ~ctl.rdata[cnt[2:0] + 3'd1];
    end else if (!in_data || ctl.op != 2'd2 || (clk_rise && cnt >= 5'd7)) begin
      dat_oe_o <= 1'b0; // Upper byte and foreign frames leave the line free
    end
  end

  AST_ADDR_MATCH: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (sel_rise && in_addr && addr_sh == 8'h80 && !alt_i) |=> ctl.op == 2'd1)
    else $error("address 128 not matched");
  AST_NOMATCH_QUIET: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (ctl.op == 2'd0) |-> !dat_oe_o)
    else $error("data driven for foreign address");
  AST_DONE_ON_END: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ctl.frame_done |-> $past(sel_fall))
    else $error("frame done without end pulse");
endmodule // seebc_shifter

// ==== dv/seebc_master.sv ====
// Bus master model: drives select and clock, pulls data low, samples the line
`timescale 1ns/1ps
module seebc_master (
  output logic sel_o,
  output logic clk_o,
  output logic low_o,
  input wire logic line_i
);
  initial begin
    sel_o = 1'b1; // Lines idle high
    clk_o = 1'b1;
    low_o = 1'b0;
  end
  // 16 data bits always; all ones in wd leaves the line free for the slave
  task automatic xfer(input logic [7:0] ba, input logic [15:0] wd, input int gap, output logic [15:0] rd);
    rd = 16'hffff;
    sel_o = 1'b0; // Select low before clock
    #100;
    for (int i = 0; i < 24; i++) begin
      if (i == 8) begin
        sel_o = 1'b1; // Address byte done
        #200;
      end
      if (i == 12 && gap > 0) #(gap); // Pause with clock high mid-transfer
      clk_o = 1'b0;
      low_o = (i < 8) ? ~ba[i] : ~wd[i - 8]; // LSB first
      #100;
      clk_o = 1'b1;
      if (i >= 8) rd[i - 8] = line_i;
      #100;
    end
    low_o = 1'b0;
    sel_o = 1'b0; // End pulse
    #200;
    sel_o = 1'b1;
    #200;
  endtask
endmodule // seebc_master

// ==== dv/test_seebc_top.sv ====
// Self-checking bench for the serial EEPROM bus control block
`timescale 1ns/1ps
module test_seebc_top;
  localparam int PC = 1000;
  localparam logic [7:0] EN = seebc_pkg::BA_ENTER;
  localparam logic [7:0] RD = seebc_pkg::BA_READ;
  localparam logic [7:0] PG = seebc_pkg::BA_PROG;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic unlock_i = 1'b0;
  logic addr_option_i = 1'b0;
  logic sel, bclk, mlow, bus_data_o, bus_data_oe_o, pump_enable_o, seen;
  logic [2:0] ref_shift_up_o, ref_shift_down_o;
  logic [15:0] rd;
  logic [9:0] a, pa;
  logic [7:0] d, t;
  logic [7:0] ob = 8'h00;
  int bad_count = 0;
  int n_compared = 0;
  int gap = 0;
  // Pull-up on the line; either party may pull it low
  wire data_line = ~(mlow | bus_data_oe_o);
  seebc_top #(.PROG_CYCLES(PC)) seebc_top_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .frame_select_line_i(sel), .bus_clock_line_i(bclk), .bus_data_i(data_line), .bus_data_o(bus_data_o),
    .bus_data_oe_o(bus_data_oe_o), .unlock_i(unlock_i), .addr_option_i(addr_option_i),
    .pump_enable_o(pump_enable_o), .ref_shift_up_o(ref_shift_up_o), .ref_shift_down_o(ref_shift_down_o));
  seebc_master seebc_master_i (.sel_o(sel), .clk_o(bclk), .low_o(mlow), .line_i(data_line));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [5:0] refx(input logic [7:0] v);
    return v[5] ? {1'b0, v[0], v[2], 1'b0, v[4], v[6]} : 6'h00;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fr(input logic [7:0] ba, input logic [15:0] wd);
    seebc_master_i.xfer(ba, wd, gap, rd);
  endtask
  task automatic enter(input logic [9:0] ad);
    fr(EN + ob, {6'h00, ad});
  endtask
  // Busy length is fixed by PROG_CYCLES, so a fixed wait of PC + 20 cycles covers it
  task automatic prog(input logic [7:0] v);
    fr(PG + ob, {8'h00, v});
    repeat (PC + 20) @(negedge clock_i);
  endtask
  task automatic rdchk(input string what, input logic [7:0] v);
    fr(RD + ob, 16'hffff);
    chk(what, {8'hff, v}, rd);
  endtask
  task automatic chk_ref(input logic [7:0] v);
    chk("ref_shift", {10'h000, refx(v)}, {10'h000, ref_shift_up_o, ref_shift_down_o});
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h460c));
    repeat (4) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk_ref(8'h00);
    chk("pump", 16'h0000, {15'h0, pump_enable_o});
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      a = 10'($urandom % 512) | 10'h010; // Bit 4 set keeps it out of the locked groups
      d = 8'($urandom);
      enter(a);
      prog(8'hff);
      fr(PG, {8'h00, d});
      repeat (50) @(negedge clock_i);
      chk("pump busy", 16'h0001, {15'h0, pump_enable_o});
      enter(a ^ 10'h001);
      fr(PG, 16'h0000);
      repeat (PC) @(negedge clock_i);
      rdchk("readback", d);
    end
    enter(seebc_pkg::PROGRAM_STATUS_ADDR);
    fr(PG, 16'h00ff);
    rdchk("status busy", 8'h02);
    repeat (PC) @(negedge clock_i);
    rdchk("status", 8'h00);
    $display("test program done");
    pa = {a[9:6], 2'b00, a[3:0]};
    unlock_i = 1'b1;
    enter(pa);
    prog(8'hff);
    prog(8'h5a);
    unlock_i = 1'b0;
    prog(8'hff);
    rdchk("locked", 8'h5a);
    $display("test protect done");
    fr(RD + seebc_pkg::BA_ALT_OFS, 16'hffff);
    chk("foreign", 16'hffff, rd);
    ob = seebc_pkg::BA_ALT_OFS;
    addr_option_i = 1'b1;
    fr(EN, {6'h00, a});
    fr(RD, 16'hffff);
    chk("plain ignored", 16'hffff, rd);
    rdchk("alt read", 8'h5a);
    gap = 20000;
    enter(a);
    rdchk("alt entry", d);
    gap = 0;
    ob = 8'h00;
    addr_option_i = 1'b0;
    $display("test option done");
    enter(seebc_pkg::TEST_MODE_BYTE_ADDR);
    for (int k = 0; k < 5; k++) begin
      t = (k == 0) ? 8'h35 : (k == 1) ? 8'hdf : 8'($urandom);
      prog(t);
      chk_ref(t);
    end
    prog(8'h28);
    enter(a ^ 10'h001);
    fr(PG, 16'h00ff);
    seen = 1'b0;
    for (int k = 0; k < PC; k++) begin
      @(negedge clock_i);
      if (pump_enable_o !== 1'b0) seen = 1'b1;
    end
    chk("pump off", 16'h0000, {15'h0, seen});
    $display("test pump done");
    enter(seebc_pkg::TEST_MODE_BYTE_ADDR);
    prog(8'h35);
    enter(a);
    fr(PG, 16'h0000);
    repeat (20) @(negedge clock_i);
    resetn_i = 1'b0;
    repeat (4) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk("pump reset", 16'h0000, {15'h0, pump_enable_o});
    chk_ref(8'h00);
    rdchk("aborted", d);
    $display("test abort done");
    unlock_i = 1'b1;
    enter(seebc_pkg::TEST_MODE_BYTE_ADDR);
    prog(8'ha0);
    for (int k = 0; k < 3; k++) begin
      enter(10'(k + (k > 0)));
      prog(k == 0 ? 8'hff : k == 1 ? 8'h55 : 8'haa);
    end
    enter(a & 10'h1fe);
    rdchk("block even", 8'h55);
    enter(a | 10'h001);
    rdchk("block odd", 8'haa);
    $display("test block done");
    end_of_test();
  end
endmodule // test_seebc_top
